/* hw/tsg_bank.sv */
// Purpose: bank of four tone generators plus a DC bias, summed to the line
// Assumes: APB slave, 20 MHz clock, 8 kHz sample rate from a divider
// Notes: no wait states; unmapped addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none
module tsg_bank (
   input wire logic clock_i,                    // System clock, 20 MHz
   input wire logic reset_n_i,                  // Async reset, active low
   input wire logic [7:0] paddr_i,              // APB byte address
   input wire logic psel_i,                     // APB select
   input wire logic penable_i,                  // APB access phase
   input wire logic pwrite_i,                   // APB write
   input wire logic [31:0] pwdata_i,            // APB write data
   output logic [31:0] prdata_o,                // APB read data
   output logic pready_o,                       // APB ready
   output logic pslverr_o,                      // APB error
   output logic signed [15:0] audio_o,          // Summed line sample
   output logic sample_valid_o,                 // New sample pulse
   output logic cid_avail_o,                    // Caller ID allowed
   output logic high_gain_o                     // Howler gain active
);
   import tsg_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [11:0] div;
      logic tick;
      logic [3:0] en;
      logic fm;
      logic bias_en;
      logic trap;
      tsg_line_t ls;
      logic [7:0] shape;
      logic [15:0] bias;
      logic [3:0][31:0] gen;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic signed [15:0] audio;
      logic vld;
      logic cid;
      logic hg;
   } tsg_bank_state_t;
   tsg_bank_state_t s_q, s_d;

   logic ringing;
   logic bias_on;
   logic [3:0] en_eff;
   tsg_shape_t gshape [TSG_NGEN];
   logic [15:0] gfreq [TSG_NGEN];
   logic signed [15:0] wave [TSG_NGEN];
   logic signed [15:0] term [5];
   logic signed [15:0] sum;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;
   logic [1:0] gidx;
   logic [1:0] row;
   logic [1:0] col;

   // ----------------------------------------------------------------
   // Line state effects
   // ----------------------------------------------------------------
   // Ringing forces A (and B for trapezoid) on, whatever the host set
   assign ringing = (s_q.ls == ringing_line_state) ||
                    (s_q.ls == reversed_ringing_line_state);
   assign bias_on = s_q.bias_en || ringing;
   assign en_eff = s_q.en |
                   {2'b00, s_q.trap && ringing, ringing};

   // Per-generator shape and frequency selection
   always_comb begin
      for (int i = 0; i < TSG_NGEN; i++) begin
         gshape[i] = tsg_shape_t'(s_q.shape[2*i +: 2]);
         gfreq[i] = s_q.gen[i][15:0];
      end
      if (ringing && s_q.trap) begin
         gshape[0] = shape_trapezoid;
         gshape[1] = shape_trapezoid;
      end
      // Negative modulator values are floored; the host must keep A above 0
      if (s_q.fm) begin
         gfreq[3] = wave[0][15] ? 16'h0000 : wave[0];
      end
   end

   // ----------------------------------------------------------------
   // Generators
   // ----------------------------------------------------------------
   for (genvar g = 0; g < TSG_NGEN; g++) begin : gen_bank
      tsg_gen u_gen (
         .clock_i(clock_i),
         .reset_n_i(reset_n_i),
         .tick_i(s_q.tick),
         .enable_i(en_eff[g]),
         .shape_i(gshape[g]),
         .freq_i(gfreq[g]),
         .amp_i(s_q.gen[g][TSG_GEN_AMP_LSB +: 16]),
         .wave_o(wave[g])
      );
   end

   // ----------------------------------------------------------------
   // Summer
   // ----------------------------------------------------------------
   // In FM the modulator is a control signal only, so it is left out
   assign term[0] = s_q.fm ? 16'sh0000 : wave[0];
   assign term[1] = wave[1];
   assign term[2] = wave[2];
   assign term[3] = wave[3];
   assign term[4] = bias_on ? s_q.bias : 16'sh0000;

   tsg_sat #(
      .N(5),
      .W(16)
   ) u_sat (
      .term_i(term),
      .invert_i(s_q.ls == reversed_ringing_line_state),
      .gain_i(s_q.ls == howler_line_state ? TSG_HOWLER_SHIFT : 2'h0),
      .sum_o(sum)
   );

   // ----------------------------------------------------------------
   // Register views
   // ----------------------------------------------------------------
   assign ctrl_word = {22'h0, s_q.ls, 1'b0, s_q.trap, s_q.bias_en,
                       s_q.fm, s_q.en};
   assign stat_word = {12'h0, s_q.hg, s_q.cid, s_q.fm, bias_on,
                       s_q.audio};
   assign gidx = paddr_i[3:2];
   assign row = pwdata_i[3:2];
   assign col = pwdata_i[1:0];

   // ----------------------------------------------------------------
   // Next state: divider, APB slave, sample output
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Sample enable from the crystal clock, no second clock domain
      s_d.tick = 1'b0;
      if (s_q.div == 12'(TSG_TICK_CYC - 1)) begin
         s_d.div = 12'h000;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 12'h001;
      end
      // Setup phase: decode and prepare the answer for the access phase
      s_d.ready = 1'b0;
      if (psel_i && !penable_i) begin
         s_d.ready = 1'b1;
         s_d.slverr = 1'b0;
         s_d.rdata = 32'h0000_0000;
         if (paddr_i == TSG_OFF_CTRL) begin
            s_d.rdata = ctrl_word;
         end else if (paddr_i == TSG_OFF_SHAPE) begin
            s_d.rdata = {24'h0, s_q.shape};
         end else if (paddr_i == TSG_OFF_BIAS) begin
            s_d.rdata = {16'h0, s_q.bias};
         end else if (paddr_i == TSG_OFF_DTMF) begin
            s_d.rdata = 32'h0000_0000;
         end else if (paddr_i == TSG_OFF_STAT) begin
            s_d.rdata = stat_word;
         end else if (paddr_i[7:4] == TSG_OFF_GEN_HI &&
                      paddr_i[1:0] == 2'h0) begin
            s_d.rdata = s_q.gen[gidx];
         end else begin
            s_d.slverr = 1'b1;
         end
      end
      // Access phase: writes land on the one edge where pready is high
      if (psel_i && penable_i && s_q.ready && pwrite_i && !s_q.slverr) begin
         if (paddr_i == TSG_OFF_CTRL) begin
            s_d.en = pwdata_i[TSG_CTRL_EN_LSB +: 4];
            s_d.fm = pwdata_i[TSG_CTRL_FM_BIT];
            s_d.bias_en = pwdata_i[TSG_CTRL_BIAS_BIT];
            s_d.trap = pwdata_i[TSG_CTRL_TRAP_BIT];
            s_d.ls = tsg_line_t'(pwdata_i[TSG_CTRL_LS_LSB +: 2]);
         end else if (paddr_i == TSG_OFF_SHAPE) begin
            s_d.shape = pwdata_i[7:0];
         end else if (paddr_i == TSG_OFF_BIAS) begin
            s_d.bias = pwdata_i[15:0];
         end else if (paddr_i == TSG_OFF_DTMF) begin
            // Row tone to B, column tone to C, both switched on
            s_d.gen[1][15:0] = tsg_hz_word(TSG_DTMF_ROW_HZ[row]);
            s_d.gen[2][15:0] = tsg_hz_word(TSG_DTMF_COL_HZ[col]);
            s_d.en[1] = 1'b1;
            s_d.en[2] = 1'b1;
         end else if (paddr_i[7:4] == TSG_OFF_GEN_HI) begin
            s_d.gen[gidx] = pwdata_i;
         end
      end
      // Output stage: audio refreshed once per sample, cid and howler flags every cycle
      s_d.vld = s_q.tick;
      if (s_q.tick) begin
         s_d.audio = sum;
      end
      s_d.cid = !s_q.fm;
      s_d.hg = (s_q.ls == howler_line_state);
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
         s_q.shape <= TSG_SHAPE_RST;
         s_q.bias <= TSG_BIAS_RST;
         s_q.gen <= {4{TSG_GEN_RST}};
         s_q.ls <= idle_line_state;
         s_q.cid <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o = s_q.rdata;
   assign pready_o = s_q.ready;
   assign pslverr_o = s_q.slverr;
   assign audio_o = s_q.audio;
   assign sample_valid_o = s_q.vld;
   assign cid_avail_o = s_q.cid;
   assign high_gain_o = s_q.hg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);

   a_bias_auto_on: assert property (ringing |-> bias_on)
      else $error("bias off in a ringing state");
   a_ring_gen_a: assert property (ringing |-> en_eff[0] &&
      (!s_q.trap || (en_eff[1] && gshape[1] == shape_trapezoid)))
      else $error("ringing generators not enabled");
   a_fm_route: assert property (s_q.fm && !wave[0][15] |->
      gfreq[3] == wave[0] && term[0] == 16'sh0000)
      else $error("modulator not routed to carrier");
   a_fm_no_cid: assert property ($rose(s_q.fm) |=> !cid_avail_o)
      else $error("caller id offered during fm");
   a_howler_gain: assert property (
      (s_q.ls == howler_line_state) [*2] |-> high_gain_o)
      else $error("howler gain not applied");
   a_enable_write: assert property (psel_i && penable_i && pready_o &&
      pwrite_i && !pslverr_o && paddr_i == TSG_OFF_CTRL |=>
      s_q.en == $past(pwdata_i[3:0]))
      else $error("enable bits not written");
   a_dtmf_load: assert property (psel_i && penable_i && pready_o &&
      pwrite_i && paddr_i == TSG_OFF_DTMF |=> en_eff[2:1] == 2'b11 &&
      s_q.gen[1][15:0] == tsg_hz_word(TSG_DTMF_ROW_HZ[$past(row)]))
      else $error("dtmf tones not loaded");
   a_gen_indep: assert property (psel_i && penable_i && pready_o &&
      pwrite_i && paddr_i == 8'h20 |=> $stable(s_q.gen[1]) && $stable(s_q.gen[3]))
      else $error("generator write leaked");
   a_tick_period: assert property (s_q.tick |=> !s_q.tick [*8])
      else $error("sample tick too frequent");
   a_sample_hold: assert property (!s_q.tick |=> $stable(audio_o))
      else $error("output changed between samples");
   a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
      else $error("apb answer missing");

   c_ringing: cover property ($rose(ringing));
   c_fm_tone: cover property (s_q.fm && en_eff[3] && s_q.tick);
   c_dtmf: cover property (pwrite_i && penable_i && paddr_i == TSG_OFF_DTMF);
   c_howler: cover property ($rose(high_gain_o));
endmodule
`default_nettype wire

/* hw/tsg_gen.sv */
// Purpose: one programmable generator: sine, triangle, trapezoid or ramp
// Assumes: tick_i is a one-cycle pulse at the sample rate
// Notes: output is registered and updates one cycle after a tick
`timescale 1ns/1ps
`default_nettype none
module tsg_gen (
   input wire logic clock_i,                    // System clock
   input wire logic reset_n_i,                  // Async reset, active low
   input wire logic tick_i,                     // Sample enable pulse
   input wire logic enable_i,                   // Generator on
   input wire tsg_pkg::tsg_shape_t shape_i,     // Waveform type
   input wire logic [15:0] freq_i,              // Phase step or ramp slope
   input wire logic signed [15:0] amp_i,        // Amplitude or ramp target
   output logic signed [15:0] wave_o            // Generator output
);
   import tsg_pkg::*;
   typedef struct packed {
      logic [15:0] phase;
      logic signed [15:0] level;
      logic signed [15:0] wave;
   } tsg_gen_state_t;
   tsg_gen_state_t s_q, s_d;
   logic [14:0] q;
   logic [29:0] par;
   logic signed [16:0] tri_w, sine_w, lvl_w;
   logic signed [17:0] trap_w;
   logic signed [15:0] shp;
   logic signed [31:0] prod;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Parabola stands in for a sine table: cheap, under 4% distortion
   always_comb begin
      s_d = s_q;
      q = s_q.phase[15] ? ~s_q.phase[14:0] : s_q.phase[14:0];
      par = s_q.phase[14:0] * (15'h7FFF - s_q.phase[14:0]);
      sine_w = s_q.phase[15] ? -$signed({2'b00, par[27:13]})
                             : $signed({2'b00, par[27:13]});
      tri_w = $signed({1'b0, q, 1'b0}) - 17'sh07FFF;
      trap_w = {tri_w, 1'b0};
      if (trap_w > 18'sh07FFF) begin
         trap_w = 18'sh07FFF;
      end else if (trap_w < -18'sh07FFF) begin
         trap_w = -18'sh07FFF;
      end
      case (shape_i)
         shape_triangle: shp = tri_w[15:0];
         shape_trapezoid: shp = trap_w[15:0];
         default: shp = sine_w[15:0];
      endcase
      prod = shp * amp_i;
      // Ramp walks toward the target, never jumps, to avoid line transients
      lvl_w = 17'(s_q.level);
      if (amp_i > s_q.level) begin
         lvl_w = lvl_w + $signed({1'b0, freq_i});
         if (lvl_w > 17'(amp_i)) lvl_w = 17'(amp_i);
      end else begin
         lvl_w = lvl_w - $signed({1'b0, freq_i});
         if (lvl_w < 17'(amp_i)) lvl_w = 17'(amp_i);
      end
      if (tick_i) begin
         if (!enable_i) begin
            s_d.phase = 16'h0000;
            s_d.wave = 16'sh0000;
         end else if (shape_i == shape_ramp) begin
            s_d.level = lvl_w[15:0];
            s_d.wave = lvl_w[15:0];
         end else begin
            s_d.phase = s_q.phase + freq_i;
            s_d.wave = prod[30:15];
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wave_o = s_q.wave;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_ramp_slew: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      tick_i && enable_i && shape_i == shape_ramp |=>
      ($signed(17'(s_q.level)) - $signed(17'($past(s_q.level))) <=
       $signed({1'b0, $past(freq_i)})) &&
      ($signed(17'($past(s_q.level))) - $signed(17'(s_q.level)) <=
       $signed({1'b0, $past(freq_i)})))
      else $error("ramp moved faster than its slope");
endmodule
`default_nettype wire

/* hw/tsg_sat.sv */
// Purpose: saturating summer of generator and bias terms
// Assumes: purely combinational, registered by the caller
// Notes: inversion and gain are applied before the final clamp
`timescale 1ns/1ps
`default_nettype none
module tsg_sat #(
   parameter int N = 5,                         // Number of terms
   parameter int W = 16                         // Term and result width
) (
   input wire logic signed [W-1:0] term_i [N],  // Terms to add
   input wire logic invert_i,                   // Negate the sum
   input wire logic [1:0] gain_i,               // Left shift of the sum
   output logic signed [W-1:0] sum_o            // Clamped sum
);
   logic signed [W+7:0] acc;
   localparam logic signed [W+7:0] MAXV = (W+8)'((1 << (W-1)) - 1);
   localparam logic signed [W+7:0] MINV = -MAXV - (W+8)'(1);

   // Wide accumulator, then one clamp instead of wrapping
   always_comb begin
      acc = '0;
      for (int i = 0; i < N; i++) begin
         acc = acc + (W+8)'(term_i[i]);
      end
      if (invert_i) acc = -acc;
      acc = acc <<< gain_i;
      if (acc > MAXV) begin
         sum_o = MAXV[W-1:0];
      end else if (acc < MINV) begin
         sum_o = MINV[W-1:0];
      end else begin
         sum_o = acc[W-1:0];
      end
   end
endmodule
`default_nettype wire

/* inc/tsg_pkg.sv */
// Purpose: shared constants and types of the tone signal generator bank
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes: all offsets except TSG_OFF_GEN_HI, an address high nibble, are byte addresses of aligned 32-bit words
package tsg_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned TSG_CLK_HZ = 20_000_000;
   localparam int unsigned TSG_FS_HZ = 8_000;
   localparam int unsigned TSG_TICK_CYC = TSG_CLK_HZ / TSG_FS_HZ;
   localparam int TSG_NGEN = 4;
   localparam logic [1:0] TSG_HOWLER_SHIFT = 2'h2;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] TSG_OFF_CTRL = 8'h00;
   localparam logic [7:0] TSG_OFF_SHAPE = 8'h04;
   localparam logic [7:0] TSG_OFF_BIAS = 8'h08;
   localparam logic [7:0] TSG_OFF_DTMF = 8'h0C;
   localparam logic [7:0] TSG_OFF_STAT = 8'h10;
   localparam logic [3:0] TSG_OFF_GEN_HI = 4'h2;
   localparam int TSG_CTRL_EN_LSB = 0;
   localparam int TSG_CTRL_FM_BIT = 4;
   localparam int TSG_CTRL_BIAS_BIT = 5;
   localparam int TSG_CTRL_TRAP_BIT = 6;
   localparam int TSG_CTRL_LS_LSB = 8;
   localparam int TSG_GEN_AMP_LSB = 16;
   localparam logic [31:0] TSG_GEN_RST = 32'h0000_0000;
   localparam logic [15:0] TSG_BIAS_RST = 16'h0000;
   localparam logic [7:0] TSG_SHAPE_RST = 8'h00;
   // ----------------------------------------------------------------
   // Types and tables
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      idle_line_state, ringing_line_state,
      reversed_ringing_line_state, howler_line_state
   } tsg_line_t;
   typedef enum logic [1:0] {
      shape_sine, shape_triangle, shape_trapezoid, shape_ramp
   } tsg_shape_t;
   localparam int unsigned TSG_DTMF_ROW_HZ [4] = '{697, 770, 852, 941};
   localparam int unsigned TSG_DTMF_COL_HZ [4] = '{1209, 1336, 1477, 1633};
   // Phase step per sample for a tone in hertz
   function automatic logic [15:0] tsg_hz_word(input int unsigned hz);
      return 16'((hz * 65536) / TSG_FS_HZ);
   endfunction
endpackage

/* tb/tsg_bank_tb_top.sv */
// Purpose: self-checking bench of the tone generator bank
// Assumes: zero wait state APB slave, 2500 cycles per sample
// Notes: line effects are judged two samples after a write, tones three
`timescale 1ns/1ps
`default_nettype none
module tsg_bank_tb_top;
   import tsg_pkg::*;
   logic clock_i, reset_n_i, psel, penable, pwrite, clr, pready, pslverr, sv, cid, hg, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [15:0] audio, mn, mx;
   logic [16:0] stp;
   int errors, compares;
   tsg_bank i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .paddr_i(paddr), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .audio_o(audio), .sample_valid_o(sv),
      .cid_avail_o(cid), .high_gain_o(hg));
   tsg_line_sink i_sink (.clock_i(clock_i), .reset_n_i(reset_n_i), .clear_i(clr),
      .valid_i(sv), .audio_i(audio), .min_o(mn), .max_o(mx), .step_o(stp));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic fail(input string m);
      errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fail("no pready");
         complete_run();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_val(rd, exp);
   endtask
   // Bounded wait for k sample pulses
   task automatic samples(input int k);
      int n, c;
      n = 0;
      c = 0;
      while (c < k && n < 3000 * k) begin
         @(posedge clock_i);
         n++;
         if (sv === 1'b1) c++;
      end
      if (c < k) begin
         fail("no sample");
         complete_run();
      end
   endtask
   task automatic audio_is(input logic [15:0] exp);
      samples(2);
      chk_val({16'h0, audio}, {16'h0, exp});
   endtask
   task automatic clear_sink();
      clr <= 1'b1;
      @(posedge clock_i);
      clr <= 1'b0;
   endtask
   function automatic logic [15:0] hzw(input int unsigned hz);
      return 16'((hz * 65536) / TSG_FS_HZ);
   endfunction
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      errors = 0;
      compares = 0;
      reset_n_i = 1'b0;
      {psel, penable, pwrite, clr, paddr, pwdata} = '0;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      chk_bit(cid, 1'b1);
      rdchk(TSG_OFF_CTRL, 32'h0);
      rdchk(TSG_OFF_SHAPE, {24'h0, TSG_SHAPE_RST});
      rdchk(TSG_OFF_BIAS, {16'h0, TSG_BIAS_RST});
      rdchk(TSG_OFF_STAT, 32'h0004_0000);
      apb(1'b0, 8'h40, 32'h0);
      chk_bit(er, 1'b1);
      $display("test reset done");
      apb(1'b1, TSG_OFF_BIAS, 32'h0100);
      apb(1'b1, TSG_OFF_CTRL, 32'h0020);
      audio_is(16'h0100);
      apb(1'b1, TSG_OFF_CTRL, 32'h0100);
      audio_is(16'h0100);
      rdchk(TSG_OFF_STAT, 32'h0005_0100);
      apb(1'b1, TSG_OFF_CTRL, 32'h0200);
      audio_is(16'hFF00);
      apb(1'b1, TSG_OFF_BIAS, 32'h3000);
      apb(1'b1, TSG_OFF_CTRL, 32'h0320);
      audio_is(16'h7FFF);
      chk_bit(hg, 1'b1);
      $display("test bias and line states done");
      apb(1'b1, TSG_OFF_CTRL, 32'h0010);
      apb(1'b0, TSG_OFF_STAT, 32'h0);
      chk_bit(rd[17], 1'b1);
      chk_bit(cid, 1'b0);
      // Every digit: row tone into B, column tone into C
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, TSG_OFF_DTMF, 32'(r * 4 + c));
            rdchk(8'h24, {16'h0, hzw(TSG_DTMF_ROW_HZ[r])});
            rdchk(8'h28, {16'h0, hzw(TSG_DTMF_COL_HZ[c])});
         end
      end
      rdchk(TSG_OFF_DTMF, 32'h0);
      rdchk(TSG_OFF_CTRL, 32'h0016);
      $display("test modulation and digits done");
      apb(1'b1, TSG_OFF_CTRL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'(8'h20 + 4 * i), {16'(i + 1), 16'(16'h0111 * (i + 1))});
      end
      for (int i = 0; i < 4; i++) begin
         rdchk(8'(8'h20 + 4 * i), {16'(i + 1), 16'(16'h0111 * (i + 1))});
      end
      // Sine on B plus triangle on C at 1 kHz
      apb(1'b1, 8'h24, {16'h1000, hzw(1000)});
      apb(1'b1, 8'h28, {16'h1000, hzw(1000)});
      apb(1'b1, TSG_OFF_SHAPE, 32'h0010);
      apb(1'b1, TSG_OFF_CTRL, 32'h0006);
      samples(2);
      clear_sink();
      samples(6);
      chk_bit(mx > 16'sd0, 1'b1);
      chk_bit(mn < 16'sd0, 1'b1);
      apb(1'b1, TSG_OFF_CTRL, 32'h0);
      // Generator changes reach the line one sample after line effects
      samples(1);
      audio_is(16'h0000);
      $display("test tones done");
      apb(1'b1, 8'h20, 32'h0400_0100);
      apb(1'b1, TSG_OFF_SHAPE, 32'h0013);
      clear_sink();
      apb(1'b1, TSG_OFF_CTRL, 32'h0001);
      samples(6);
      chk_val({16'h0, audio}, 32'h0000_0400);
      chk_bit(stp <= 17'h00100, 1'b1);
      $display("test ramp done");
      // A parked at a positive ramp level modulates D, whose own step is 0
      apb(1'b1, 8'h2C, 32'h1000_0000);
      apb(1'b1, TSG_OFF_CTRL, 32'h0019);
      samples(4);
      chk_bit(audio > 16'sh0000, 1'b1);
      chk_bit(audio < 16'sh0400, 1'b1);
      // Host side amplitude change: rewrite the carrier amplitude
      apb(1'b1, 8'h2C, 32'h0000_0000);
      samples(1);
      audio_is(16'h0000);
      $display("test frequency modulation done");
      // Trapezoid ringing: B joins A, steep edges, bias lifts the line
      apb(1'b1, TSG_OFF_CTRL, 32'h0140);
      samples(3);
      clear_sink();
      samples(3);
      chk_bit(stp > 17'h00C00, 1'b1);
      chk_bit(mn > 16'sh1000, 1'b1);
      $display("test trapezoid ringing done");
      complete_run();
   end
endmodule
`default_nettype wire

/* tb/tsg_line_sink.sv */
// Purpose: line side sink that records the summed samples
// Assumes: one sample per valid pulse
// Notes: keeps extremes and the largest step since the last clear
`timescale 1ns/1ps
`default_nettype none
module tsg_line_sink (
   input wire logic clock_i,               // System clock
   input wire logic reset_n_i,             // Reset, active low
   input wire logic clear_i,               // Restart the record
   input wire logic valid_i,               // Sample strobe
   input wire logic signed [15:0] audio_i, // Line sample
   output logic signed [15:0] min_o,       // Lowest sample
   output logic signed [15:0] max_o,       // Highest sample
   output logic [16:0] step_o              // Largest step
);
   logic signed [15:0] last_q;
   logic signed [16:0] dif;
   logic [16:0] mag;
   // Step size; a jump here is what the line would see as a transient
   assign dif = 17'(audio_i) - 17'(last_q);
   assign mag = dif[16] ? 17'(-dif) : 17'(dif);
   // Record each accepted sample
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         min_o <= 16'h0000;
         max_o <= 16'h0000;
         step_o <= 17'h00000;
         last_q <= 16'h0000;
      end else if (clear_i) begin
         min_o <= 16'h7FFF;
         max_o <= 16'h8000;
         step_o <= 17'h00000;
         last_q <= audio_i;
      end else if (valid_i) begin
         min_o <= (audio_i < min_o) ? audio_i : min_o;
         max_o <= (audio_i > max_o) ? audio_i : max_o;
         step_o <= (mag > step_o) ? mag : step_o;
         last_q <= audio_i;
      end
   end
endmodule
`default_nettype wire
